// *** intflag_ctrl.sv ***
// Purpose: Priority level, trap, vector select and request flag registers
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Hardware sets beat software clears on flag registers
// How it works
// (R1) Read-only bit shows level above seven
// (R2) Level is high bit over low field
// (R3) Unimplemented bits read zero, ignore writes
// (R4) Four trap bits, hardware set, writable
// (R5) Alternate vector table when select set
// (R6) Read-only bit shows mask instruction active
// (R7) Polarity bit picks falling or rising edge
// (R8) One flag per source, hardware sets
// (R9) First flags upper byte layout
// (R10) First flags lower byte layout
// (R11) Second flag register layout
// (R12) Third flag register layout
// (R13) Low priority field locked when nesting off
// (R14) Low field 111 blocks user sources
// (R15) Hardware set wins over software clear
`timescale 1ns/100ps
module intflag_ctrl
    import intflag_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [DATA_W-1:0] RDATA,
    input wire logic [3:0] TRAP_EVENT,
    input wire logic TRAP_TAKEN,
    input wire logic TRAP_DONE,
    input wire logic MASK_INSTR_START,
    input wire logic MASK_INSTR_END,
    input wire logic [DATA_W-1:0] FLAGS1_SET,
    input wire logic [DATA_W-1:0] FLAGS2_SET,
    input wire logic [DATA_W-1:0] FLAGS3_SET,
    input wire logic [NUM_EXT-1:0] EXT_PIN,
    output logic [3:0] PRIO_LEVEL,
    output logic USER_BLOCKED,
    output logic ALT_VECTOR_SEL,
    output logic [DATA_W-1:0] FLAGS1,
    output logic [DATA_W-1:0] FLAGS2,
    output logic [DATA_W-1:0] FLAGS3,
    output logic IRQ
);
    logic prio_high_ff, nxt_prio_high;
    logic [2:0] prio_low_ff, nxt_prio_low;
    logic [15:0] trap_ff, nxt_trap;
    logic [15:0] vec_ff, nxt_vec;
    logic [15:0] f1_ff, nxt_f1;
    logic [15:0] f2_ff, nxt_f2;
    logic [15:0] f3_ff, nxt_f3;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [NUM_IRQ_EV-1:0] ists_ff, nxt_ists, ien_ff, nxt_ien;
    logic irq_ff, nxt_irq;
    logic [3:0] lvl_ff, nxt_lvl;
    logic blk_ff, nxt_blk;
    logic [NUM_EXT-1:0] ext_hit;
    logic [15:0] core_view, arith_view;
    logic [15:0] set1, set2, set3;
    logic wr_trap, wr_vec, wr_f1, wr_f2, wr_f3, wr_ar;

    edge_detect u_edge (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .pin(EXT_PIN),
        .falling_sel(vec_ff[2:0]), // [R7]
        .hit(ext_hit)
    );

    // Write decodes
    assign wr_trap = WR_EN && ADDR == OFF_TRAP_NEST;
    assign wr_vec = WR_EN && ADDR == OFF_VEC_EDGE;
    assign wr_f1 = WR_EN && ADDR == OFF_FLAGS_1;
    assign wr_f2 = WR_EN && ADDR == OFF_FLAGS_2;
    assign wr_f3 = WR_EN && ADDR == OFF_FLAGS_3;
    assign wr_ar = WR_EN && ADDR == OFF_ARITH_STAT;

    // Hardware set vectors, external edges merged at their bits
    always_comb begin
        set1 = FLAGS1_SET & FLAGS1_MASK; // [R9] [R10]
        set1[FLAG1_EXT0_BIT] = set1[FLAG1_EXT0_BIT] | ext_hit[0];
        set2 = FLAGS2_SET & FLAGS2_MASK; // [R11]
        set2[FLAG2_EXT1_BIT] = set2[FLAG2_EXT1_BIT] | ext_hit[1];
        set2[FLAG2_EXT2_BIT] = set2[FLAG2_EXT2_BIT] | ext_hit[2];
        set3 = FLAGS3_SET & FLAGS3_MASK; // [R12]
    end

    // Read views of the composed registers
    assign core_view = {12'h000, prio_high_ff, 3'h0} & CORE_MASK; // [R1]
    assign arith_view = {8'h00, prio_low_ff, 5'h00} & ARITH_MASK;

    // Next-state for all register state
    always_comb begin
        nxt_prio_high = prio_high_ff;
        if (TRAP_TAKEN)
            nxt_prio_high = 1'b1; // [R1]
        else if (TRAP_DONE)
            nxt_prio_high = 1'b0;
        nxt_prio_low = prio_low_ff;
        if (wr_ar && !trap_ff[NEST_OFF_BIT])
            nxt_prio_low = WDATA[PRIO_LO_LSB +: 3]; // [R13]
        // Trap bits: write, then hardware sets on top
        nxt_trap = trap_ff;
        if (wr_trap)
            nxt_trap = WDATA & TRAP_MASK; // [R3]
        nxt_trap[TRAP_OSC_BIT +: 4] = nxt_trap[TRAP_OSC_BIT +: 4]
                                      | TRAP_EVENT; // [R4] [R15]
        nxt_vec = vec_ff;
        if (wr_vec)
            nxt_vec = (WDATA & VEC_WR_MASK)
                      | (vec_ff & ~VEC_WR_MASK); // [R5] [R3]
        if (MASK_INSTR_START)
            nxt_vec[MASK_INSTR_BIT] = 1'b1; // [R6]
        else if (MASK_INSTR_END)
            nxt_vec[MASK_INSTR_BIT] = 1'b0;
        // Flags: software value, then hardware set wins
        nxt_f1 = (wr_f1 ? (WDATA & FLAGS1_MASK) : f1_ff) | set1; // [R8] [R15]
        nxt_f2 = (wr_f2 ? (WDATA & FLAGS2_MASK) : f2_ff) | set2; // [R15]
        nxt_f3 = (wr_f3 ? (WDATA & FLAGS3_MASK) : f3_ff) | set3; // [R15]
        // Interrupt events: trap, ext edges, mask instr end
        nxt_ists = ists_ff;
        if (WR_EN && ADDR == OFF_IRQ_CLR)
            nxt_ists = ists_ff & ~WDATA[NUM_IRQ_EV-1:0];
        nxt_ists = nxt_ists | {MASK_INSTR_END, ext_hit[2], |ext_hit[1:0],
                               |TRAP_EVENT};
        nxt_ien = ien_ff;
        if (WR_EN && ADDR == OFF_IRQ_EN)
            nxt_ien = WDATA[NUM_IRQ_EV-1:0];
        nxt_irq = |(nxt_ists & nxt_ien);
        nxt_lvl = {nxt_prio_high, nxt_prio_low}; // [R2]
        nxt_blk = nxt_prio_low == PRIO_LO_TOP || nxt_prio_high; // [R14]
        // Read mux; unmapped reads zero
        nxt_rdata = rdata_ff;
        if (RD_EN) begin
            case (ADDR)
                OFF_CORE_CTRL: nxt_rdata = core_view;
                OFF_TRAP_NEST: nxt_rdata = trap_ff & TRAP_MASK; // [R3]
                OFF_VEC_EDGE: nxt_rdata = vec_ff & VEC_MASK;
                OFF_FLAGS_1: nxt_rdata = f1_ff;
                OFF_FLAGS_2: nxt_rdata = f2_ff;
                OFF_FLAGS_3: nxt_rdata = f3_ff;
                OFF_ARITH_STAT: nxt_rdata = arith_view;
                OFF_IRQ_STAT: nxt_rdata = {12'h000, ists_ff};
                OFF_IRQ_EN: nxt_rdata = {12'h000, ien_ff};
                default: nxt_rdata = RESET_VAL;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prio_high_ff <= 1'b0;
            prio_low_ff <= 3'h0;
            trap_ff <= RESET_VAL;
            vec_ff <= RESET_VAL;
            f1_ff <= RESET_VAL;
            f2_ff <= RESET_VAL;
            f3_ff <= RESET_VAL;
            rdata_ff <= RESET_VAL;
            ists_ff <= '0;
            ien_ff <= '0;
            irq_ff <= 1'b0;
            lvl_ff <= 4'h0;
            blk_ff <= 1'b0;
        end else begin
            prio_high_ff <= nxt_prio_high;
            prio_low_ff <= nxt_prio_low;
            trap_ff <= nxt_trap;
            vec_ff <= nxt_vec;
            f1_ff <= nxt_f1;
            f2_ff <= nxt_f2;
            f3_ff <= nxt_f3;
            rdata_ff <= nxt_rdata;
            ists_ff <= nxt_ists;
            ien_ff <= nxt_ien;
            irq_ff <= nxt_irq;
            lvl_ff <= nxt_lvl;
            blk_ff <= nxt_blk;
        end
    end

    // Outputs straight from flops; flag outputs are the flag state registers themselves
    assign RDATA = rdata_ff;
    assign PRIO_LEVEL = lvl_ff;
    assign USER_BLOCKED = blk_ff;
    assign ALT_VECTOR_SEL = vec_ff[ALT_VEC_BIT]; // [R5]
    assign FLAGS1 = f1_ff;
    assign FLAGS2 = f2_ff;
    assign FLAGS3 = f3_ff;
    assign IRQ = irq_ff;

    // Register path checks; a later software clear may drop a held flag
    high_bit_a: assert property (@(posedge CORE_CLK) // [R1]
        disable iff (!RST_N)
        (RD_EN && ADDR == OFF_CORE_CTRL)
        |=> RDATA == {12'h000, $past(prio_high_ff), 3'h0})
        else $error("core control read wrong");
    level_join_a: assert property (@(posedge CORE_CLK) // [R2]
        disable iff (!RST_N)
        (wr_ar && !trap_ff[NEST_OFF_BIT])
        |=> PRIO_LEVEL == {prio_high_ff, $past(WDATA[PRIO_LO_LSB +: 3])})
        else $error("level not composed");
    unimpl_zero_a: assert property (@(posedge CORE_CLK) // [R3] [R12]
        disable iff (!RST_N)
        (RD_EN && ADDR == OFF_FLAGS_3) |=> (RDATA & ~FLAGS3_MASK) == 16'h0000)
        else $error("unused bits read nonzero");
    trap_set_a: assert property (@(posedge CORE_CLK) // [R4]
        disable iff (!RST_N)
        TRAP_EVENT[0] |=> trap_ff[TRAP_OSC_BIT])
        else $error("trap bit not set");
    alt_vec_a: assert property (@(posedge CORE_CLK) // [R5]
        disable iff (!RST_N)
        wr_vec |=> ALT_VECTOR_SEL == $past(WDATA[ALT_VEC_BIT]))
        else $error("vector select not stored");
    mask_instr_a: assert property (@(posedge CORE_CLK) // [R6]
        disable iff (!RST_N)
        MASK_INSTR_START |=> vec_ff[MASK_INSTR_BIT])
        else $error("mask instr status not set");
    set_wins_a: assert property (@(posedge CORE_CLK) // [R15] [R9]
        disable iff (!RST_N)
        (wr_f1 && FLAGS1_SET[15]) |=> FLAGS1[15])
        else $error("clear beat hardware set");
    flag_hold_a: assert property (@(posedge CORE_CLK) // [R8] [R11]
        disable iff (!RST_N)
        (FLAGS2_SET[0] && !wr_f2)
        |=> FLAGS2[0] ##1 (FLAGS2[0] || $past(wr_f2)))
        else $error("flag not held");
    nest_lock_a: assert property (@(posedge CORE_CLK) // [R13]
        disable iff (!RST_N)
        (wr_ar && trap_ff[NEST_OFF_BIT]) |=> $stable(prio_low_ff))
        else $error("low field written while locked");
    block_top_a: assert property (@(posedge CORE_CLK) // [R14]
        disable iff (!RST_N)
        (prio_low_ff == PRIO_LO_TOP || prio_high_ff) |-> USER_BLOCKED)
        else $error("level seven not blocking");
    ext_flag_a: assert property (@(posedge CORE_CLK) // [R7] [R10]
        disable iff (!RST_N)
        ext_hit[0] |=> FLAGS1[FLAG1_EXT0_BIT])
        else $error("ext0 edge not flagged");
endmodule

// *** intflag_pkg.sv ***
// Purpose: Constants for the interrupt status, trap and flag registers
// Assumes: 16-bit register port, one clock
// Notes: Offsets are register word indices on the plain register port
package intflag_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register indices
    localparam logic [3:0] OFF_CORE_CTRL = 4'h0;
    localparam logic [3:0] OFF_TRAP_NEST = 4'h1;
    localparam logic [3:0] OFF_VEC_EDGE = 4'h2;
    localparam logic [3:0] OFF_FLAGS_1 = 4'h3;
    localparam logic [3:0] OFF_FLAGS_2 = 4'h4;
    localparam logic [3:0] OFF_FLAGS_3 = 4'h5;
    localparam logic [3:0] OFF_ARITH_STAT = 4'h6;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h7;
    localparam logic [3:0] OFF_IRQ_CLR = 4'h8;
    localparam logic [3:0] OFF_IRQ_EN = 4'h9;
    // Implemented bit masks
    localparam logic [15:0] CORE_MASK = 16'h0008;
    localparam logic [15:0] TRAP_MASK = 16'h801E;
    localparam logic [15:0] VEC_MASK = 16'hC007;
    localparam logic [15:0] VEC_WR_MASK = 16'h8007;
    localparam logic [15:0] FLAGS1_MASK = 16'hBF8F;
    localparam logic [15:0] FLAGS2_MASK = 16'h201F;
    localparam logic [15:0] FLAGS3_MASK = 16'h2102;
    localparam logic [15:0] ARITH_MASK = 16'h00E0;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    // Field positions
    localparam int CORE_HIGH_BIT = 3;
    localparam int NEST_OFF_BIT = 15;
    localparam int ALT_VEC_BIT = 15;
    localparam int MASK_INSTR_BIT = 14;
    localparam int PRIO_LO_LSB = 5;
    localparam int TRAP_OSC_BIT = 1;
    localparam int FLAG2_EXT2_BIT = 13;
    localparam int FLAG2_EXT1_BIT = 4;
    localparam int FLAG1_EXT0_BIT = 0;
    localparam logic [2:0] PRIO_LO_TOP = 3'h7;
    localparam int NUM_EXT = 3;
    localparam int NUM_IRQ_EV = 4;
endpackage

// *** edge_detect.sv ***
// Purpose: Synchronise external request pins and detect selected edge
// Assumes: Pins are asynchronous to CORE_CLK
// Notes: One output pulse per chosen edge
`timescale 1ns/100ps
module edge_detect
    import intflag_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_EXT-1:0] pin,
    input wire logic [NUM_EXT-1:0] falling_sel,
    output logic [NUM_EXT-1:0] hit
);
    logic [NUM_EXT-1:0] meta_ff, sync_ff, last_ff;
    logic [NUM_EXT-1:0] nxt_meta, nxt_sync, nxt_last;

    // Sampling chain; only sync_ff reads meta_ff
    always_comb begin
        nxt_meta = pin;
        nxt_sync = meta_ff;
        nxt_last = sync_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            last_ff <= nxt_last;
        end
    end

    // Edge choice per input
    genvar g;
    generate
        for (g = 0; g < NUM_EXT; g++) begin : g_ch
            assign hit[g] = falling_sel[g] ? (last_ff[g] & ~sync_ff[g])
                                           : (~last_ff[g] & sync_ff[g]); // [R7]
        end
    endgenerate

    fall_edge_a: assert property (@(posedge clk) // [R7]
        disable iff (!rst_n)
        (falling_sel[0] && $fell(sync_ff[0])) |-> hit[0])
        else $error("falling edge missed");
    rise_edge_a: assert property (@(posedge clk) // [R7]
        disable iff (!rst_n)
        (hit[0] && !falling_sel[0]) |-> $rose(sync_ff[0]))
        else $error("rising hit without edge");
endmodule

// *** event_src_model.sv ***
// Purpose: Behavioural model of the core and the peripheral event sources
// Assumes: The bench issues one command per cycle on cmd_valid
// Notes: Pulses last exactly one cycle; pins keep their commanded level
`timescale 1ns/100ps
module event_src_model
    import intflag_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_kind,
    input wire logic [15:0] cmd_data,
    output logic [3:0] trap_event,
    output logic trap_taken,
    output logic trap_done,
    output logic mask_start,
    output logic mask_end,
    output logic [15:0] set1,
    output logic [15:0] set2,
    output logic [15:0] set3,
    output logic [NUM_EXT-1:0] pins
);
    // Registered so the design sees each pulse on one edge only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {trap_event, trap_taken, trap_done, mask_start, mask_end} <= '0;
            {set1, set2, set3} <= '0;
            pins <= '0;
        end else begin
            {trap_event, trap_taken, trap_done, mask_start, mask_end} <= '0;
            {set1, set2, set3} <= '0;
            if (cmd_valid) begin
                case (cmd_kind)
                    4'h0: trap_event <= cmd_data[3:0];
                    4'h1: trap_taken <= 1'b1;
                    4'h2: trap_done <= 1'b1;
                    4'h3: mask_start <= 1'b1;
                    4'h4: mask_end <= 1'b1;
                    4'h5: set1 <= cmd_data;
                    4'h6: set2 <= cmd_data;
                    4'h7: set3 <= cmd_data;
                    4'h8: pins <= cmd_data[NUM_EXT-1:0];
                    default: ;
                endcase
            end
        end
    end
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the interrupt status and flag block
// Assumes: Read data sampled just after the edge that takes the strobe
// Notes: Table rows cover register layouts, hand tests cover events
`timescale 1ns/100ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("CHECK FAILED %s expected %h seen %h", what, \
    exp, got); end end
module testbench
    import intflag_pkg::*;
;
    typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_kind = '0;
    logic [15:0] cmd_data = '0;
    logic [DATA_W-1:0] rdata, flags1, flags2, flags3, d;
    logic [15:0] set1, set2, set3;
    logic [3:0] trap_event, prio_level;
    logic trap_taken, trap_done, mask_start, mask_end;
    logic user_blocked, alt_vector_sel, irq;
    logic [NUM_EXT-1:0] pins;
    int n_errors = 0;
    int compares = 0;
    // Write, read back, expected; order matters for the locked field
    row_t rows [10] = '{
        '{4'h0, 16'hFFFF, 16'h0000},
        '{4'h1, 16'hFFFF, 16'h801E},
        '{4'h6, 16'hFFFF, 16'h0000},
        '{4'h1, 16'h0000, 16'h0000},
        '{4'h6, 16'hFFFF, 16'h00E0},
        '{4'h2, 16'hFFFF, 16'h8007},
        '{4'h3, 16'hFFFF, 16'hBF8F},
        '{4'h4, 16'hFFFF, 16'h201F},
        '{4'h5, 16'hFFFF, 16'h2102},
        '{4'hA, 16'hFFFF, 16'h0000}};

    always #4 clk = ~clk;

    intflag_ctrl intflag_ctrl_inst (.CORE_CLK(clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en),
        .RDATA(rdata), .TRAP_EVENT(trap_event), .TRAP_TAKEN(trap_taken),
        .TRAP_DONE(trap_done), .MASK_INSTR_START(mask_start),
        .MASK_INSTR_END(mask_end), .FLAGS1_SET(set1), .FLAGS2_SET(set2),
        .FLAGS3_SET(set3), .EXT_PIN(pins), .PRIO_LEVEL(prio_level),
        .USER_BLOCKED(user_blocked), .ALT_VECTOR_SEL(alt_vector_sel),
        .FLAGS1(flags1), .FLAGS2(flags2), .FLAGS3(flags3), .IRQ(irq));

    event_src_model event_src_model_inst (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
        .trap_event(trap_event), .trap_taken(trap_taken),
        .trap_done(trap_done), .mask_start(mask_start),
        .mask_end(mask_end), .set1(set1), .set2(set2), .set3(set3),
        .pins(pins));

    // Bus cycles: strobes drop on the edge that takes them
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    // Slack covers the two-flop pin synchroniser and the registered irq
    task automatic ev(input logic [3:0] k, input logic [15:0] v);
        @(posedge clk);
        cmd_kind <= k;
        cmd_data <= v;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic clr();
        wr(OFF_FLAGS_1, 16'h0000);
        wr(OFF_FLAGS_2, 16'h0000);
        wr(OFF_FLAGS_3, 16'h0000);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        `CHK("outputs at reset", 7'h00, {prio_level, user_blocked,
            alt_vector_sel, irq})
        for (int i = 0; i < 10; i++) begin
            if (i != 8) begin
                rd(i[3:0], d);
                `CHK("reset value", 16'h0000, d)
            end
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            `CHK("register", rows[i].e, d)
        end
        `CHK("level", 4'h7, prio_level)
        `CHK("blocked", 1'b1, user_blocked)
        `CHK("alt table", 1'b1, alt_vector_sel)
        wr(OFF_VEC_EDGE, 16'h0000);
        wr(OFF_ARITH_STAT, 16'h00A0);
        @(posedge clk);
        `CHK("alt off", 1'b0, alt_vector_sel)
        `CHK("level five", 4'h5, prio_level)
        `CHK("not blocked", 1'b0, user_blocked)
        ev(4'h1, 16'h0000);
        `CHK("level high", 4'hD, prio_level)
        `CHK("blocked high", 1'b1, user_blocked)
        rd(OFF_CORE_CTRL, d);
        `CHK("core high", 16'h0008, d)
        ev(4'h2, 16'h0000);
        rd(OFF_CORE_CTRL, d);
        `CHK("core low", 16'h0000, d)
        // Hardware flag sets through the source model
        clr();
        ev(4'h5, 16'hFFFF);
        ev(4'h6, 16'hFFFF);
        ev(4'h7, 16'hFFFF);
        `CHK("flags1 set", 16'hBF8F, flags1)
        `CHK("flags2 set", 16'h201F, flags2)
        `CHK("flags3 set", 16'h2102, flags3)
        // Set pulse and clearing write land on the same edge
        @(posedge clk);
        cmd_kind <= 4'h5;
        cmd_data <= 16'h8001;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        addr <= OFF_FLAGS_1;
        wdata <= 16'h0000;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1 `CHK("set beats clear", 16'h8001, flags1)
        clr();
        ev(4'h0, 16'h000F);
        rd(OFF_TRAP_NEST, d);
        `CHK("traps", 16'h001E, d)
        wr(OFF_TRAP_NEST, 16'h0000);
        ev(4'h3, 16'h0000);
        rd(OFF_VEC_EDGE, d);
        `CHK("mask active", 16'h4000, d)
        ev(4'h4, 16'h0000);
        rd(OFF_VEC_EDGE, d);
        `CHK("mask ended", 16'h0000, d)
        // Rising, then falling, then rising ignored under falling select
        ev(4'h8, 16'h0007);
        `CHK("rising", 3'b111, {flags1[0], flags2[13], flags2[4]})
        clr();
        wr(OFF_VEC_EDGE, 16'h0007);
        ev(4'h8, 16'h0000);
        `CHK("falling", 3'b111, {flags1[0], flags2[13], flags2[4]})
        clr();
        ev(4'h8, 16'h0007);
        `CHK("wrong edge", 3'b000, {flags1[0], flags2[13], flags2[4]})
        // Interrupt: raise, mask, clear
        wr(OFF_IRQ_CLR, 16'h000F);
        wr(OFF_IRQ_EN, 16'h0001);
        ev(4'h0, 16'h0002);
        `CHK("irq raised", 1'b1, irq)
        rd(OFF_IRQ_STAT, d);
        `CHK("irq status", 16'h0001, d)
        wr(OFF_IRQ_EN, 16'h0000);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_CLR, 16'h0001);
        wr(OFF_IRQ_EN, 16'h0001);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        // Mid-run reset must drop the alternate table select again
        wr(OFF_VEC_EDGE, 16'h8000);
        @(posedge clk);
        `CHK("alt before reset", 1'b1, alt_vector_sel)
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_VEC_EDGE, d);
        `CHK("vector after reset", 16'h0000, d)
        `CHK("outputs after reset", 7'h00, {prio_level, user_blocked,
            alt_vector_sel, irq})
        print_verdict();
    end
endmodule
